// *** core/sfi_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef SFI_REGS_SVH
`define SFI_REGS_SVH
// Device register offsets on the serial link
`define SFI_TAP_TH    6'h1D
`define SFI_TAP_DUR   6'h21
`define SFI_TAP_LAT   6'h22
`define SFI_TAP_WIN   6'h23
`define SFI_ACT_TH    6'h24
`define SFI_STL_TH    6'h25
`define SFI_STL_TIME  6'h26
`define SFI_FALL_TH   6'h28
`define SFI_FALL_TIME 6'h29
`define SFI_IRQ_EN    6'h2E
`define SFI_IRQ_MAP   6'h2F
`define SFI_IRQ_FLAGS 6'h30
`define SFI_DATA_LO   6'h32
`define SFI_DATA_HI   6'h37
`define SFI_BUF_CTL   6'h38
`define SFI_BUF_STAT  6'h39
// Flag bit positions
`define SFI_F_DRDY    7
`define SFI_F_STAP    6
`define SFI_F_DTAP    5
`define SFI_F_ACT     4
`define SFI_F_STILL   3
`define SFI_F_FALL    2
`define SFI_F_WMARK   1
`define SFI_F_OVR     0
// Flags cleared by a read of the flag register
`define SFI_STICKY    8'h7C
// Buffer control fields
`define SFI_BC_MODE   7:6
`define SFI_BC_TRIG   5
`define SFI_BC_LVL    4:0
`define SFI_DEPTH     6'h20
`define SFI_CFG_RST   8'h00
// Host register offsets on APB
`define SFI_H_CTRL    8'h00
`define SFI_H_TXD     8'h04
`define SFI_H_RXL     8'h08
`define SFI_H_RXH     8'h0C
`define SFI_H_STAT    8'h10
// Host control fields
`define SFI_HC_HDR    7:0
`define SFI_HC_NB     10:8
// Timing
`define SFI_CLK_NS    40
`define SFI_HALF_CYC  4'h8
`define SFI_GAP_NS    5000
`define SFI_GAP_CYC   ((`SFI_GAP_NS + `SFI_CLK_NS - 1) / `SFI_CLK_NS)
`endif

// *** core/sfi_pkg.sv ***
// Types shared by both ends of the sample buffer link
package sfi_pkg;
  // Buffer modes in field order
  typedef enum logic [1:0] {SFI_BYPASS, SFI_FIFO, SFI_STREAM, SFI_TRIGGER} sfi_mode_t;
  // Host link sequencer states
  typedef enum logic [2:0] {SFI_IDLE, SFI_LEAD, SFI_LOW, SFI_HIGH, SFI_GAP} sfi_hst_t;
endpackage

// *** core/sfi_if.sv ***
// Serial link and interrupt pins between host and sensor
interface sfi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic irq_pin_one;
  logic irq_pin_two;
  modport dev (input sclk, cs_n, mosi, output miso, irq_pin_one, irq_pin_two);
  modport hst (output sclk, cs_n, mosi, input miso, irq_pin_one, irq_pin_two);
endinterface

// *** core/sfi_hst.sv ***
// Host end: APB command registers driving the serial link master
`include "sfi_regs.svh"
module sfi_hst (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Link to the sensor
  sfi_if.hst               link
);
  sfi_pkg::sfi_hst_t st, next_st;
  logic [10:0] ctrl, next_ctrl;
  logic [31:0] txd, next_txd;
  logic [63:0] sh, next_sh, rxd, next_rxd;
  logic [6:0]  bits, next_bits;
  logic [7:0]  cnt, next_cnt;
  logic        sclk, next_sclk, cs_n, next_cs_n, mosi, next_mosi;
  logic [2:0]  miso_q, next_miso_q;
  logic [1:0]  irq1_q, irq2_q;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  logic        acc, start, busy, half_end;

  assign acc      = psel_in & penable_in & pready_out;
  assign busy     = (st != sfi_pkg::SFI_IDLE);
  assign start    = acc & pwrite_in & (paddr_in == `SFI_H_CTRL) & !busy;
  assign half_end = (cnt == {4'h0, `SFI_HALF_CYC - 4'h1});

  // APB answer one cycle after setup, decoded in setup
  always_comb begin
    next_pready  = psel_in & ~penable_in;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_ctrl    = ctrl;
    next_txd     = txd;
    unique case (paddr_in)
      `SFI_H_CTRL: next_prdata = {21'h000000, ctrl};
      `SFI_H_TXD:  next_prdata = txd;
      `SFI_H_RXL:  next_prdata = rxd[31:0];
      `SFI_H_RXH:  next_prdata = rxd[63:32];
      `SFI_H_STAT: next_prdata = {29'h0000_0000, irq2_q[1], irq1_q[1], busy};
      default:     next_pslverr = psel_in & ~penable_in;
    endcase
    if (start)
      next_ctrl = pwdata_in[10:0];
    if (acc & pwrite_in & (paddr_in == `SFI_H_TXD))
      next_txd = pwdata_in;
  end

  // Link sequencer: mode 3 clock, gap after every frame
  always_comb begin
    next_st     = st;
    next_sh     = sh;
    next_rxd    = rxd;
    next_bits   = bits;
    next_cnt    = cnt + 8'h01;
    next_sclk   = sclk;
    next_cs_n   = cs_n;
    next_mosi   = mosi;
    next_miso_q = {miso_q[1:0], link.miso};
    unique case (st)
      sfi_pkg::SFI_IDLE: begin
        next_cnt = 8'h00;
        if (start) begin
          next_sh   = {pwdata_in[`SFI_HC_HDR], txd, 24'h000000};
          next_bits = {pwdata_in[`SFI_HC_NB], 3'h0} + 7'h08;
          next_cs_n = 1'b0;
          next_st   = sfi_pkg::SFI_LEAD;
        end
      end
      sfi_pkg::SFI_LEAD, sfi_pkg::SFI_HIGH: begin
        if (half_end) begin
          next_cnt = 8'h00;
          if (bits == 7'h00) begin
            next_cs_n = 1'b1;
            next_rxd  = sh;
            next_st   = sfi_pkg::SFI_GAP;
          end else begin
            next_sclk = 1'b0;
            next_mosi = sh[63];
            next_st   = sfi_pkg::SFI_LOW;
          end
        end
      end
      sfi_pkg::SFI_LOW: begin
        if (half_end) begin
          next_cnt  = 8'h00;
          next_sclk = 1'b1;
          next_sh   = {sh[62:0], miso_q[2]};
          next_bits = bits - 7'h01;
          next_st   = sfi_pkg::SFI_HIGH;
        end
      end
      sfi_pkg::SFI_GAP: begin
        if (cnt == 8'(`SFI_GAP_CYC - 1))
          next_st = sfi_pkg::SFI_IDLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st          <= sfi_pkg::SFI_IDLE;
      ctrl        <= 11'h000;
      txd         <= 32'h0000_0000;
      sh          <= 64'h0;
      rxd         <= 64'h0;
      bits        <= 7'h00;
      cnt         <= 8'h00;
      sclk        <= 1'b1;
      cs_n        <= 1'b1;
      mosi        <= 1'b1;
      miso_q      <= 3'h0;
      irq1_q      <= 2'h0;
      irq2_q      <= 2'h0;
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      st          <= next_st;
      ctrl        <= next_ctrl;
      txd         <= next_txd;
      sh          <= next_sh;
      rxd         <= next_rxd;
      bits        <= next_bits;
      cnt         <= next_cnt;
      sclk        <= next_sclk;
      cs_n        <= next_cs_n;
      mosi        <= next_mosi;
      miso_q      <= next_miso_q;
      irq1_q      <= {irq1_q[0], link.irq_pin_one};
      irq2_q      <= {irq2_q[0], link.irq_pin_two};
      prdata_out  <= next_prdata;
      pready_out  <= next_pready;
      pslverr_out <= next_pslverr;
    end
  end

  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.mosi = mosi;
endmodule

// *** core/sfi_dev.sv ***
// Sensor end: serial registers, detectors, interrupt pins, sample buffer
//
// Implementation choice: the serial link interface to the registers.
`include "sfi_regs.svh"
// Overview of operation
// - Two pins, enable mask, routing register
// - Host disables interrupts before configuring
// - Data flags clear by data reads; others by source read
// - New-sample flag follows unread data
// - Single tap: short over-threshold event
// - Double tap: second inside latency-window slot
// - Activity when above motion threshold
// - Stillness below threshold longer than time
// - Fall below threshold longer than time
// - Watermark while count reaches level
// - Overrun: overwrite in bypass, full otherwise
// - 32-entry buffer, four modes
// - Bypass keeps buffer empty
// - FIFO mode stops storing when full
// - Stream mode keeps newest 32
// - Trigger keeps last n, then FIFO
// - Host waits 5 us after trigger
// - One trigger until bypass re-arm
// - Data reads pop oldest sample
// - Partial sample read loses remaining bytes
// - Host leaves 5 us after data read
// - Fast links raise chip select between reads
module sfi_dev (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  // Link to the host
  sfi_if.dev               link,
  // Sample stream and magnitude
  input  wire logic        sample_valid_in,
  input  wire logic [15:0] x_axis_data_in,
  input  wire logic [15:0] y_axis_data_in,
  input  wire logic [15:0] z_axis_data_in,
  input  wire logic [7:0]  peak_mag_in,
  // Time bases: 625 us, 5 ms, 1 s pulses
  input  wire logic        tick_tap_in,
  input  wire logic        tick_fall_in,
  input  wire logic        tick_sec_in,
  // Buffer level
  output logic      [5:0]  buffer_level_out
);
  // Link synchronisers, bit 0 read only by bit 1
  logic [2:0] sck_q, cs_q;
  logic [1:0] mosi_q;
  logic       sck_rise, sck_fall, cs_hi, cs_rise;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic       hdr, next_hdr, rd, next_rd, mb, next_mb, miso, next_miso;
  logic [5:0] addr, next_addr;
  logic [7:0] rx, next_rx, tx, next_tx, rdata, wdata;
  logic       wr_en, rd_load;
  // Configuration
  logic [7:0] tap_threshold, tap_duration_limit, tap_latency_time, second_tap_window;
  logic [7:0] motion_threshold, stillness_threshold, stillness_time;
  logic [7:0] fall_threshold, fall_time, irq_enable_mask, irq_pin_routing, buffer_control;
  logic [7:0] next_cfg [0:11];
  // Buffer and flags
  logic [47:0] mem [0:31];
  logic [47:0] byp_data, next_byp_data, cur;
  logic [4:0]  wp, next_wp, rp, next_rp;
  logic [5:0]  count, next_count;
  logic        trig_done, next_trig_done, unread, next_unread, ovr, next_ovr;
  logic        data_rd, next_data_rd, data_end, push, pop, trig;
  logic [4:0]  sticky, next_sticky;
  logic [7:0]  irq_flags;
  logic        pin1, next_pin1, pin2, next_pin2, pin_prev;
  sfi_pkg::sfi_mode_t mode;
  // Tap detector
  logic       tap_on, next_tap_on, armed, next_armed, second, next_second;
  logic [7:0] tap_cnt, next_tap_cnt;
  logic [9:0] gap_cnt, next_gap_cnt;
  logic       ev_stap, ev_dtap, above_tap;
  logic [9:0] lat2, win_end;
  // Stillness (0) and fall (1) timers
  logic [1:0] low_ev;

  assign sck_rise = sck_q[1] & ~sck_q[2];
  assign sck_fall = ~sck_q[1] & sck_q[2];
  assign cs_hi    = cs_q[1];
  assign cs_rise  = cs_q[1] & ~cs_q[2];
  assign wdata    = {rx[6:0], mosi_q[1]};
  assign mode     = sfi_pkg::sfi_mode_t'(buffer_control[`SFI_BC_MODE]);
  assign cur      = (mode == sfi_pkg::SFI_BYPASS) ? byp_data : mem[rp];

  // Serial slave: header byte, then data bytes, mode 3 timing
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_hdr     = hdr;
    next_rd      = rd;
    next_mb      = mb;
    next_addr    = addr;
    next_rx      = rx;
    next_tx      = tx;
    next_miso    = miso;
    wr_en        = 1'b0;
    rd_load      = 1'b0;
    if (cs_hi) begin
      next_bit_cnt = 3'h0;
      next_hdr     = 1'b1;
    end else if (sck_rise) begin
      next_rx      = wdata;
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        if (hdr) begin
          next_hdr  = 1'b0;
          next_rd   = rx[6];
          next_mb   = rx[5];
          next_addr = {rx[4:0], mosi_q[1]};
        end else begin
          wr_en = ~rd;
          if (mb)
            next_addr = addr + 6'h01;
        end
      end
    end else if (sck_fall) begin
      if (bit_cnt == 3'h0 && !hdr && rd) begin
        rd_load   = 1'b1; // Read side effects fire on first bit out
        next_miso = rdata[7];
        next_tx   = {rdata[6:0], 1'b0};
      end else begin
        next_miso = tx[7];
        next_tx   = {tx[6:0], 1'b0};
      end
    end
  end

  // Read data mux
  always_comb begin
    rdata = 8'h00;
    unique case (addr)
      `SFI_TAP_TH:    rdata = tap_threshold;
      `SFI_TAP_DUR:   rdata = tap_duration_limit;
      `SFI_TAP_LAT:   rdata = tap_latency_time;
      `SFI_TAP_WIN:   rdata = second_tap_window;
      `SFI_ACT_TH:    rdata = motion_threshold;
      `SFI_STL_TH:    rdata = stillness_threshold;
      `SFI_STL_TIME:  rdata = stillness_time;
      `SFI_FALL_TH:   rdata = fall_threshold;
      `SFI_FALL_TIME: rdata = fall_time;
      `SFI_IRQ_EN:    rdata = irq_enable_mask;
      `SFI_IRQ_MAP:   rdata = irq_pin_routing;
      `SFI_IRQ_FLAGS: rdata = irq_flags;
      `SFI_BUF_CTL:   rdata = buffer_control;
      `SFI_BUF_STAT:  rdata = {trig_done, 1'b0, count};
      default: begin
        if (addr >= `SFI_DATA_LO && addr <= `SFI_DATA_HI)
          rdata = cur[{addr[2:0] - 3'h2, 3'h0} +: 8];
      end
    endcase
  end

  // Register writes
  always_comb begin
    next_cfg = '{tap_threshold, tap_duration_limit, tap_latency_time,
                 second_tap_window, motion_threshold, stillness_threshold,
                 stillness_time, fall_threshold, fall_time, irq_enable_mask,
                 irq_pin_routing, buffer_control};
    if (wr_en) begin
      unique case (addr)
        `SFI_TAP_TH:    next_cfg[0] = wdata;
        `SFI_TAP_DUR:   next_cfg[1] = wdata;
        `SFI_TAP_LAT:   next_cfg[2] = wdata;
        `SFI_TAP_WIN:   next_cfg[3] = wdata;
        `SFI_ACT_TH:    next_cfg[4] = wdata;
        `SFI_STL_TH:    next_cfg[5] = wdata;
        `SFI_STL_TIME:  next_cfg[6] = wdata;
        `SFI_FALL_TH:   next_cfg[7] = wdata;
        `SFI_FALL_TIME: next_cfg[8] = wdata;
        `SFI_IRQ_EN:    next_cfg[9] = wdata;
        `SFI_IRQ_MAP:   next_cfg[10] = wdata;
        `SFI_BUF_CTL:   next_cfg[11] = wdata;
        default:        next_cfg[0] = tap_threshold;
      endcase
    end
  end

  // Tap detector on sample boundaries
  assign above_tap = peak_mag_in > tap_threshold;
  assign lat2      = {1'b0, tap_latency_time, 1'b0};
  assign win_end   = lat2 + {1'b0, second_tap_window, 1'b0};
  always_comb begin
    next_tap_on  = tap_on;
    next_tap_cnt = (tap_on && tick_tap_in && tap_cnt != 8'hFF) ? tap_cnt + 8'h01 : tap_cnt;
    next_armed   = armed;
    next_second  = second;
    next_gap_cnt = (armed && tick_tap_in) ? gap_cnt + 10'h001 : gap_cnt;
    ev_stap      = 1'b0;
    ev_dtap      = 1'b0;
    if (armed && gap_cnt >= win_end)
      next_armed = 1'b0;
    if (sample_valid_in) begin
      if (above_tap && !tap_on) begin
        next_tap_on  = 1'b1;
        next_tap_cnt = 8'h00;
        next_second  = armed && gap_cnt > lat2 && gap_cnt < win_end;
      end else if (!above_tap && tap_on) begin
        next_tap_on = 1'b0;
        if (tap_duration_limit != 8'h00 && tap_cnt < tap_duration_limit) begin
          if (second) begin
            ev_dtap    = 1'b1;
            next_armed = 1'b0;
          end else begin
            ev_stap      = 1'b1;
            next_armed   = 1'b1;
            next_gap_cnt = 10'h000;
          end
        end
        next_second = 1'b0;
      end
    end
  end

  // Stillness and fall timers share one form
  for (genvar i = 0; i < 2; i++) begin : g_low
    logic [7:0] th, lim, cnt, next_cnt;
    logic       tick, below, next_below, hit, next_hit;
    assign th   = (i == 0) ? stillness_threshold : fall_threshold;
    assign lim  = (i == 0) ? stillness_time : fall_time;
    assign tick = (i == 0) ? tick_sec_in : tick_fall_in;
    always_comb begin
      next_below = below;
      next_cnt   = (below && tick && cnt != 8'hFF) ? cnt + 8'h01 : cnt;
      next_hit   = hit;
      low_ev[i]  = 1'b0;
      if (sample_valid_in && peak_mag_in >= th) begin
        next_below = 1'b0;
        next_cnt   = 8'h00;
        next_hit   = 1'b0;
      end else if (sample_valid_in)
        next_below = 1'b1;
      if (below && !hit && cnt > lim) begin
        low_ev[i] = 1'b1;
        next_hit  = 1'b1;
      end
    end
    always_ff @(posedge mclk_in) begin
      if (srst_in) begin
        below <= 1'b0;
        cnt   <= 8'h00;
        hit   <= 1'b0;
      end else begin
        below <= next_below;
        cnt   <= next_cnt;
        hit   <= next_hit;
      end
    end
  end

  // Buffer, data-ready, overrun, trigger
  assign data_end = data_rd && (cs_rise || (rd_load && addr == `SFI_BUF_CTL));
  assign pop      = data_end && mode != sfi_pkg::SFI_BYPASS && count != 6'h00;
  assign trig     = mode == sfi_pkg::SFI_TRIGGER && !trig_done &&
                    (buffer_control[`SFI_BC_TRIG] ? pin2 : pin1) && !pin_prev;
  always_comb begin
    next_wp        = wp;
    next_rp        = rp;
    next_count     = count;
    next_trig_done = trig_done;
    next_unread    = unread;
    next_ovr       = ovr;
    next_byp_data  = byp_data;
    next_data_rd   = (data_rd && !data_end) ||
                     (rd_load && addr >= `SFI_DATA_LO && addr <= `SFI_DATA_HI);
    push           = 1'b0;
    if (data_end)
      next_unread = 1'b0;
    if (pop || (data_end && mode == sfi_pkg::SFI_BYPASS))
      next_ovr = 1'b0;
    if (pop) begin
      next_rp    = rp + 5'h01;
      next_count = count - 6'h01;
    end
    if (mode == sfi_pkg::SFI_BYPASS) begin
      next_wp        = 5'h00;
      next_rp        = 5'h00;
      next_count     = 6'h00;
      next_trig_done = 1'b0;
      if (sample_valid_in) begin
        next_byp_data = {z_axis_data_in, y_axis_data_in, x_axis_data_in};
        next_unread   = 1'b1;
        if (unread)
          next_ovr = 1'b1;
      end
    end else if (sample_valid_in) begin
      if (next_count != `SFI_DEPTH) begin
        push       = 1'b1;
        next_count = next_count + 6'h01;
        if (next_count == `SFI_DEPTH)
          next_ovr = 1'b1;
      end else begin
        next_ovr = 1'b1;
        if (mode == sfi_pkg::SFI_STREAM ||
            (mode == sfi_pkg::SFI_TRIGGER && !trig_done)) begin
          push    = 1'b1;
          next_rp = next_rp + 5'h01;
        end
      end
      if (push)
        next_wp = wp + 5'h01;
    end
    if (trig) begin
      next_trig_done = 1'b1;
      if (next_count > {1'b0, buffer_control[`SFI_BC_LVL]}) begin
        next_rp    = next_rp + 5'(next_count - {1'b0, buffer_control[`SFI_BC_LVL]});
        next_count = {1'b0, buffer_control[`SFI_BC_LVL]};
      end
    end
  end

  // Flags and pins
  assign irq_flags = {(mode == sfi_pkg::SFI_BYPASS) ? unread : count != 6'h00,
                      sticky,
                      count >= {1'b0, buffer_control[`SFI_BC_LVL]},
                      ovr};
  always_comb begin
    next_sticky = sticky;
    if (rd_load && addr == `SFI_IRQ_FLAGS)
      next_sticky = 5'h00;
    next_sticky = next_sticky | {ev_stap, ev_dtap,
                                 sample_valid_in && peak_mag_in > motion_threshold,
                                 low_ev[0], low_ev[1]};
    next_pin1 = |(irq_flags & irq_enable_mask & ~irq_pin_routing);
    next_pin2 = |(irq_flags & irq_enable_mask & irq_pin_routing);
  end

  always_ff @(posedge mclk_in) begin
    if (push)
      mem[wp] <= {z_axis_data_in, y_axis_data_in, x_axis_data_in};
  end

  // Registers
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      {sck_q, cs_q, mosi_q} <= 8'hFF;
      {bit_cnt, hdr, rd, mb, addr, rx, tx, miso} <= 29'h00000000;
      {tap_threshold, tap_duration_limit, tap_latency_time} <= {3{`SFI_CFG_RST}};
      {second_tap_window, motion_threshold, stillness_threshold} <= {3{`SFI_CFG_RST}};
      {stillness_time, fall_threshold, fall_time} <= {3{`SFI_CFG_RST}};
      {irq_enable_mask, irq_pin_routing, buffer_control} <= {3{`SFI_CFG_RST}};
      {byp_data, wp, rp, count} <= 64'h0;
      {trig_done, unread, ovr, data_rd, sticky, pin1, pin2, pin_prev} <= 12'h000;
      {tap_on, tap_cnt, armed, second, gap_cnt} <= 21'h000000;
      buffer_level_out <= 6'h00;
    end else begin
      sck_q  <= {sck_q[1:0], link.sclk};
      cs_q   <= {cs_q[1:0], link.cs_n};
      mosi_q <= {mosi_q[0], link.mosi};
      {bit_cnt, hdr, rd, mb, addr, rx, tx, miso} <=
        {next_bit_cnt, next_hdr, next_rd, next_mb, next_addr, next_rx, next_tx, next_miso};
      {tap_threshold, tap_duration_limit, tap_latency_time} <=
        {next_cfg[0], next_cfg[1], next_cfg[2]};
      {second_tap_window, motion_threshold, stillness_threshold} <=
        {next_cfg[3], next_cfg[4], next_cfg[5]};
      {stillness_time, fall_threshold, fall_time} <= {next_cfg[6], next_cfg[7], next_cfg[8]};
      {irq_enable_mask, irq_pin_routing, buffer_control} <=
        {next_cfg[9], next_cfg[10], next_cfg[11]};
      {byp_data, wp, rp, count} <= {next_byp_data, next_wp, next_rp, next_count};
      {trig_done, unread, ovr, data_rd, sticky} <=
        {next_trig_done, next_unread, next_ovr, next_data_rd, next_sticky};
      {pin1, pin2} <= {next_pin1, next_pin2};
      pin_prev <= buffer_control[`SFI_BC_TRIG] ? pin2 : pin1;
      {tap_on, tap_cnt, armed, second, gap_cnt} <=
        {next_tap_on, next_tap_cnt, next_armed, next_second, next_gap_cnt};
      buffer_level_out <= next_count;
    end
  end

  assign link.miso        = miso;
  assign link.irq_pin_one = pin1;
  assign link.irq_pin_two = pin2;
endmodule

// *** tb/sfi_link_asserts.sv ***
// Timing and framing checks on the link between host and sensor ends
module sfi_link_asserts (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic irq_pin_one,
  input wire logic irq_pin_two
);
  logic [7:0] gap_cnt, next_gap_cnt;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);
  // Cycles spent with chip select high, saturating
  always_comb begin
    next_gap_cnt = gap_cnt;
    if (!cs_n)
      next_gap_cnt = 8'h00;
    else if (gap_cnt != 8'hFF)
      next_gap_cnt = gap_cnt + 8'h01;
  end
  // Gap counter register
  always_ff @(posedge mclk_in) begin
    if (srst_in)
      gap_cnt <= 8'hFF;
    else
      gap_cnt <= next_gap_cnt;
  end
  sclk_idle_a: assert property (cs_n |-> sclk)
    else $error("link clock not idle high");
  lead_time_a: assert property ($fell(cs_n) |-> sclk[*8] ##1 !sclk)
    else $error("lead before first bit wrong");
  low_phase_a: assert property ($fell(sclk) |-> (!sclk)[*8] ##1 sclk)
    else $error("link clock low phase wrong");
  high_phase_a: assert property ($rose(sclk) |-> sclk[*8])
    else $error("link clock high phase short");
  mosi_hold_a: assert property (!cs_n && sclk && $past(!cs_n && sclk) |-> $stable(mosi))
    else $error("command line moved while clock high");
  miso_hold_a: assert property (!cs_n && sclk && $past(!cs_n && sclk) |-> $stable(miso))
    else $error("reply line moved while clock high");
  frame_gap_a: assert property ($fell(cs_n) |-> gap_cnt >= 8'h7D)
    else $error("frames closer than the pop gap");
  frame_tail_a: assert property ($rose(cs_n) |-> $past(sclk, 8))
    else $error("frame closed inside a byte");
  cover property ($fell(cs_n));
  cover property ($rose(irq_pin_one));
  cover property ($rose(irq_pin_two));
endmodule

// *** tb/tb_sample_fifo_and_interrupt_logic.sv ***
// Bench joining host and sensor ends over the link
`include "sfi_regs.svh"
module tb_sample_fifo_and_interrupt_logic;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, sel = 1'b0, en = 1'b0, wen = 1'b0, sv = 1'b0;
  logic        rdy, perr, err;
  logic [7:0]  adr = 8'h00, mag = 8'h00;
  logic [15:0] xd = 16'h0000;
  logic [31:0] wd = 32'h0, pq;
  logic [5:0]  lvl;
  logic [63:0] rx;
  int          n_mismatch = 0, checks_done = 0, cyc = 0;
  sfi_if lnk();
  sfi_hst i_sfi_hst (.mclk_in(clk), .srst_in(rst), .psel_in(sel), .penable_in(en),
    .pwrite_in(wen), .paddr_in(adr), .pwdata_in(wd), .prdata_out(pq), .pready_out(rdy),
    .pslverr_out(perr), .link(lnk));
  sfi_dev i_sfi_dev (.mclk_in(clk), .srst_in(rst), .link(lnk), .sample_valid_in(sv),
    .x_axis_data_in(xd), .y_axis_data_in(xd + 16'h0100), .z_axis_data_in(xd + 16'h0200),
    .peak_mag_in(mag), .tick_tap_in(sv), .tick_fall_in(sv), .tick_sec_in(sv),
    .buffer_level_out(lvl));
  sfi_link_asserts i_sfi_link_asserts (.mclk_in(clk), .srst_in(rst), .sclk(lnk.sclk),
    .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso(lnk.miso), .irq_pin_one(lnk.irq_pin_one),
    .irq_pin_two(lnk.irq_pin_two));
  // Clock and hang guard
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One APB transfer, held until pready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    sel <= 1'b1;
    wen <= w;
    adr <= a;
    wd  <= d;
    @(posedge clk);
    en <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    err = perr;
    rx  = {rx[31:0], pq};
    sel <= 1'b0;
    en  <= 1'b0;
    @(posedge clk);
  endtask
  // Link frame of header plus n bytes, reply image left in rx
  task automatic frm(input logic [7:0] h, input logic [2:0] n, input logic [31:0] t);
    bus(1'b1, `SFI_H_TXD, t);
    bus(1'b1, `SFI_H_CTRL, {21'h0, n, h});
    do bus(1'b0, `SFI_H_STAT, 32'h0); while (rx[0] === 1'b1);
    bus(1'b0, `SFI_H_RXH, 32'h0);
    bus(1'b0, `SFI_H_RXL, 32'h0);
  endtask
  task automatic wrb(input logic [5:0] a, input logic [7:0] d);
    frm({2'b00, a}, 3'h1, {d, 24'h0});
  endtask
  task automatic rdb(input logic [5:0] a);
    frm({2'b10, a}, 3'h1, 32'h0);
  endtask
  // One sample pulse
  task automatic push(input logic [15:0] k, input logic [7:0] m);
    sv  <= 1'b1;
    xd  <= k;
    mag <= m;
    @(posedge clk);
    sv <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_reset();
    rdb(`SFI_IRQ_FLAGS);
    check(rx[7:0], 8'h02);
    rdb(`SFI_BUF_STAT);
    check(rx[7:0], 8'h00);
    bus(1'b0, 8'h14, 32'h0);
    check(err, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_fifo();
    wrb(`SFI_BUF_CTL, 8'h44);
    for (int k = 0; k < 33; k++) push(16'(k), 8'h00);
    check(lvl, 6'h20);
    rdb(`SFI_IRQ_FLAGS);
    check(rx[7:0], 8'h83);
    frm({2'b11, `SFI_DATA_LO}, 3'h6, 32'h0);
    check(rx[47:0], 48'h000000010002);
    check(lvl, 6'h1F);
    wrb(`SFI_BUF_CTL, 8'h00);
    check(lvl, 6'h00);
    wrb(`SFI_BUF_CTL, 8'h9F);
    for (int k = 0; k < 34; k++) push(16'(k), 8'h00);
    check(lvl, 6'h20);
    frm({2'b11, `SFI_DATA_LO}, 3'h6, 32'h0);
    check(rx[47:0], 48'h020002010202);
    $display("buffer test done");
  endtask
  task automatic t_pins();
    wrb(`SFI_IRQ_EN, 8'h00);
    wrb(`SFI_IRQ_MAP, 8'h02);
    wrb(`SFI_IRQ_EN, 8'h02);
    check({lnk.irq_pin_one, lnk.irq_pin_two}, 2'b01);
    bus(1'b0, `SFI_H_STAT, 32'h0);
    check(rx[2:1], 2'b10);
    wrb(`SFI_IRQ_MAP, 8'h00);
    check({lnk.irq_pin_one, lnk.irq_pin_two}, 2'b10);
    wrb(`SFI_IRQ_EN, 8'h00);
    check({lnk.irq_pin_one, lnk.irq_pin_two}, 2'b00);
    $display("pin test done");
  endtask
  // Single, double tap, stillness and fall, one tick per sample
  task automatic t_tap();
    wrb(`SFI_TAP_TH, 8'h80);
    frm({2'b01, `SFI_TAP_DUR}, 3'h4, 32'h0401_0440);
    frm({2'b01, `SFI_STL_TH}, 3'h4, 32'h1000_0010);
    for (int k = 0; k < 7; k++) push(16'(k), (k % 5 == 0) ? 8'hFF : 8'h00);
    rdb(`SFI_IRQ_FLAGS);
    check(rx[6:2], 5'h1F);
    $display("tap test done");
  endtask
  task automatic t_trig();
    wrb(`SFI_ACT_TH, 8'h40);
    wrb(`SFI_BUF_CTL, 8'h00);
    wrb(`SFI_BUF_CTL, 8'hC2);
    wrb(`SFI_IRQ_EN, 8'h10);
    for (int k = 0; k < 6; k++) push(16'(k), (k == 5) ? 8'hFF : 8'h00);
    repeat (130) @(posedge clk);
    check(lvl, 6'h02);
    rdb(`SFI_IRQ_FLAGS);
    check(rx[4], 1'b1);
    rdb(`SFI_IRQ_FLAGS);
    check(rx[4], 1'b0);
    push(16'h0006, 8'hFF);
    repeat (130) @(posedge clk);
    check(lvl, 6'h03);
    rdb(`SFI_BUF_STAT);
    check(rx[7:0], 8'h83);
    $display("trigger test done");
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_fifo();
    t_pins();
    t_tap();
    t_trig();
    end_sim();
  end
endmodule
